//--- src/fast_parallel_config_port.sv
// fast parallel configuration load port: pin handshake, word capture, init sequencing, registers
// Function
// R1 - user mode: all lines high; request low reconfigures
// R2 - status held low through power-on delay
// R3 - load complete low until transfer ends
// R4 - request low drops status and load-complete quickly
// R5 - host holds request low at least 2 us
// R6 - status low pulse 268 to 1506 us
// R7 - release status after request high, unless held
// R8 - host waits before first word clock edge
// R9 - ratio one: one word per rising edge
// R10 - width selects bits 7..0, 15..0 or 31..0
// R11 - host limits word clock rate and duty
// R12 - load complete rises only after whole image
// R13 - two falling edges after load complete start init
// R14 - oscillator init: user mode 175 to 437 us
// R15 - user clock init: enable wait, 8576 edges
// R16 - word clock ignored once configured
// R17 - init done driven low once option loaded
// R18 - one word per edge only without decompress/security
// R19 - host restarts load when status drops
`timescale 1ns/1ns
module fast_parallel_config_port #(
    parameter logic [15:0] POR_CYCLES        = 16'(fpl_pkg::POR_DEFAULT_CYCLES),
    parameter logic [15:0] STATUS_LOW_CYCLES = 16'(fpl_pkg::STATUS_LOW_MIN_CYCLES),
    parameter logic [15:0] USRCLK_EDGES      = 16'(fpl_pkg::USRCLK_INIT_EDGES)
) (
    input  wire logic        core_clk,
    input  wire logic        reset,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_write,
    input  wire logic        reg_read,
    output logic      [31:0] reg_rdata,
    output logic             irq,
    input  wire logic        config_request_n,
    input  wire logic        status_n_in,
    output logic             status_n_out,
    output logic             status_n_oe,
    input  wire logic        load_complete_in,
    output logic             load_complete_out,
    output logic             load_complete_oe,
    input  wire logic        init_done_n_in,
    output logic             init_done_n_out,
    output logic             init_done_n_oe,
    input  wire logic        cfg_word_clock,
    input  wire logic [31:0] cfg_data,
    input  wire logic        user_init_clock,
    output logic             user_mode
);

    // ==========================================================
    // pin synchronisers
    fpl_pkg::pin_type   pins_raw;
    fpl_pkg::pin_type   pins;
    fpl_pkg::pin_type   pin_rise;
    fpl_pkg::pin_type   pin_fall;
    logic        [31:0] data_sync;

    assign pins_raw = '{init_done_n: init_done_n_in, load_complete: load_complete_in,
                        user_init_clock: user_init_clock, status_n: status_n_in,
                        request_n: config_request_n, cfg_word_clock: cfg_word_clock};

    edge_sync #(.WIDTH($bits(fpl_pkg::pin_type))) u_pin_sync (
        .core_clk (core_clk),
        .reset    (reset),
        .async_in (pins_raw),
        .sync_out (pins),
        .rise     (pin_rise),
        .fall     (pin_fall)
    );

    // data goes through the same depth so it lines up with the detected clock edge
    edge_sync #(.WIDTH(fpl_pkg::DATA_W)) u_data_sync (
        .core_clk (core_clk),
        .reset    (reset),
        .async_in (cfg_data),
        .sync_out (data_sync),
        .rise     (),
        .fall     ()
    );

    // ==========================================================
    // state and registers
    fpl_pkg::phase_type phase;
    fpl_pkg::ctrl_type  ctrl;
    fpl_pkg::irq_type   irq_status;
    fpl_pkg::irq_type   irq_mask;
    fpl_pkg::irq_type   events;
    logic        [31:0] word_count;
    logic        [31:0] words_rx;
    logic        [31:0] last_word;
    logic        [31:0] masked_word;
    logic        [1:0]  ratio_cnt;
    logic        [1:0]  falls_seen;
    logic        [3:0]  enable_wait;
    logic               init_option;
    logic               word_edge;
    logic               single_ratio;
    logic               image_done;
    logic               init_ready;
    logic               enter_hold;
    logic               enter_init;
    logic               timer_start;
    logic        [15:0] timer_load;
    logic               timer_tick;
    logic               timer_done;

    assign single_ratio = !ctrl.decompress && !ctrl.secure;                             // [R18]
    assign word_edge    = (phase == fpl_pkg::phase_load) && pin_rise.cfg_word_clock
                          && (single_ratio || ratio_cnt == 2'(fpl_pkg::PACKED_RATIO - 1)); // [R9] [R18]
    assign image_done   = (phase == fpl_pkg::phase_load) && (words_rx == word_count);    // [R12]
    assign enter_hold   = pin_fall.request_n && (phase != fpl_pkg::phase_por);           // [R1]
    assign enter_init   = image_done && !enter_hold;
    assign init_ready   = timer_done && !timer_start
                          && (falls_seen == 2'(fpl_pkg::INIT_FALL_EDGES));               // [R13]

    // one timer serves power-on, the status pulse and initialisation in turn
    assign timer_start = enter_hold || enter_init;
    assign timer_load  = enter_hold ? STATUS_LOW_CYCLES                                  // [R6]
                         : ctrl.use_user_clk ? USRCLK_EDGES                              // [R15]
                         : 16'(fpl_pkg::INIT_OSC_MIN_CYCLES);                            // [R14]
    assign timer_tick  = (phase == fpl_pkg::phase_init && ctrl.use_user_clk)
                         ? (pin_rise.user_init_clock && enable_wait == 4'h0) : 1'b1;     // [R15]

    interval_timer #(.WIDTH(fpl_pkg::TIMER_W), .INIT_COUNT(POR_CYCLES)) u_timer (
        .core_clk   (core_clk),
        .reset      (reset),
        .start      (timer_start),
        .load_value (timer_load),
        .tick       (timer_tick),
        .done       (timer_done)
    );

    // ==========================================================
    // phase sequencing
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            phase <= fpl_pkg::phase_por;
        end else if (enter_hold) begin
            phase <= fpl_pkg::phase_reset_hold;                                          // [R1] [R4]
        end else begin
            unique case (phase)
                fpl_pkg::phase_por: begin
                    if (timer_done) begin                                                // [R2]
                        phase <= pins.request_n ? fpl_pkg::phase_wait_release : fpl_pkg::phase_reset_hold;
                    end
                end
                fpl_pkg::phase_reset_hold: begin
                    if (timer_done && pins.request_n) begin                              // [R6] [R7]
                        phase <= fpl_pkg::phase_wait_release;
                    end
                end
                fpl_pkg::phase_wait_release: begin
                    if (pins.status_n) begin                                             // [R7]
                        phase <= fpl_pkg::phase_load;
                    end
                end
                fpl_pkg::phase_load: begin
                    if (image_done) begin                                                // [R12]
                        phase <= fpl_pkg::phase_init;
                    end else if (!pins.status_n) begin
                        phase <= fpl_pkg::phase_error;
                    end
                end
                fpl_pkg::phase_init: begin
                    if (init_ready) begin                                                // [R14] [R15]
                        phase <= fpl_pkg::phase_user;
                    end
                end
                fpl_pkg::phase_user: begin
                    phase <= fpl_pkg::phase_user;                                        // [R16]
                end
                fpl_pkg::phase_error: begin
                    phase <= fpl_pkg::phase_error;
                end
                default: begin
                    phase <= fpl_pkg::phase_error;
                end
            endcase
        end
    end

    // ==========================================================
    // word capture; the mask keeps narrow modes clean above their lanes
    always_comb begin
        unique case (ctrl.width)
            fpl_pkg::width_8:  masked_word = {24'h000000, data_sync[7:0]};               // [R10]
            fpl_pkg::width_16: masked_word = {16'h0000, data_sync[15:0]};                // [R10]
            fpl_pkg::width_32: masked_word = data_sync;                                  // [R10]
            default:           masked_word = data_sync;
        endcase
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            words_rx    <= 32'h0000_0000;
            last_word   <= 32'h0000_0000;
            ratio_cnt   <= 2'h0;
            init_option <= 1'b0;
        end else if (enter_hold) begin
            words_rx    <= 32'h0000_0000;
            ratio_cnt   <= 2'h0;
            init_option <= 1'b0;
        end else if (phase == fpl_pkg::phase_load && pin_rise.cfg_word_clock && !image_done) begin
            ratio_cnt <= word_edge ? 2'h0 : ratio_cnt + 2'h1;
            if (word_edge) begin                                                         // [R9]
                words_rx  <= words_rx + 32'h0000_0001;
                last_word <= masked_word;
                if (words_rx == 32'h0000_0000 && masked_word[fpl_pkg::OPTION_BIT]) begin
                    init_option <= 1'b1;                                                 // [R17]
                end
            end
        end
    end

    // init needs two falling edges from the host and, with the user clock, a short enable wait
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            falls_seen  <= 2'h0;
            enable_wait <= 4'h0;
        end else if (enter_init) begin
            falls_seen  <= 2'h0;
            enable_wait <= 4'(fpl_pkg::USRCLK_ENABLE_CYCLES);                            // [R15]
        end else if (phase == fpl_pkg::phase_init) begin
            if (pin_fall.cfg_word_clock && falls_seen != 2'(fpl_pkg::INIT_FALL_EDGES)) begin
                falls_seen <= falls_seen + 2'h1;                                         // [R13]
            end
            if (enable_wait != 4'h0) begin
                enable_wait <= enable_wait - 4'h1;
            end
        end
    end

    // ==========================================================
    // pin drives: open drain, enable high pulls the line low
    assign status_n_out      = 1'b0;
    assign load_complete_out = 1'b0;
    assign init_done_n_out   = 1'b0;
    assign status_n_oe       = (phase == fpl_pkg::phase_por) || (phase == fpl_pkg::phase_reset_hold)
                               || (phase == fpl_pkg::phase_error);                       // [R2] [R4]
    assign load_complete_oe  = (phase != fpl_pkg::phase_init) && (phase != fpl_pkg::phase_user); // [R3] [R12]
    assign init_done_n_oe    = init_option && (phase != fpl_pkg::phase_user);            // [R17]
    assign user_mode         = (phase == fpl_pkg::phase_user);                           // [R1]

    // ==========================================================
    // register slave and interrupts
    assign events = '{load_error:   phase == fpl_pkg::phase_load && !image_done && !pins.status_n,
                      user_mode:    phase == fpl_pkg::phase_init && init_ready,
                      load_done:    enter_init,
                      request_seen: pin_fall.request_n};

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            ctrl       <= fpl_pkg::CTRL_RESET;
            word_count <= fpl_pkg::WORD_COUNT_RESET;
            irq_mask   <= fpl_pkg::IRQ_MASK_RESET;
        end else if (reg_write) begin
            unique case (reg_addr)
                fpl_pkg::CTRL_OFFSET:       ctrl       <= {27'h0000000, reg_wdata[4:0]};
                fpl_pkg::WORD_COUNT_OFFSET: word_count <= reg_wdata;
                fpl_pkg::IRQ_MASK_OFFSET:   irq_mask   <= reg_wdata[3:0];
                default: ;
            endcase
        end
    end

    // a new event in the clearing read's cycle survives, so none is lost
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            irq_status <= '0;
        end else if (reg_read && reg_addr == fpl_pkg::IRQ_STATUS_OFFSET) begin
            irq_status <= events;
        end else begin
            irq_status <= irq_status | events;
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_read) begin
            unique case (reg_addr)
                fpl_pkg::CTRL_OFFSET:       reg_rdata <= ctrl;
                fpl_pkg::WORD_COUNT_OFFSET: reg_rdata <= word_count;
                fpl_pkg::PHASE_OFFSET:      reg_rdata <= {24'h000000, pins.init_done_n, pins.load_complete,
                                                          pins.status_n, pins.request_n, init_option, phase};
                fpl_pkg::WORDS_RX_OFFSET:   reg_rdata <= words_rx;
                fpl_pkg::IRQ_STATUS_OFFSET: reg_rdata <= {28'h0000000, irq_status};
                fpl_pkg::IRQ_MASK_OFFSET:   reg_rdata <= {28'h0000000, irq_mask};
                fpl_pkg::LAST_WORD_OFFSET:  reg_rdata <= last_word;
                default:                    reg_rdata <= 32'h0000_0000;
            endcase
        end else begin
            reg_rdata <= 32'h0000_0000;
        end
    end

    assign irq = |(irq_status & irq_mask);

    // ==========================================================
    // assertions and their helper counters
    logic [15:0] status_low_cnt;
    logic [15:0] init_cnt;

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            status_low_cnt <= 16'h0000;
            init_cnt       <= 16'h0000;
        end else begin
            status_low_cnt <= (status_n_oe && status_low_cnt != 16'hffff) ? status_low_cnt + 16'h0001 : 16'h0000;
            init_cnt       <= (phase == fpl_pkg::phase_init && init_cnt != 16'hffff) ? init_cnt + 16'h0001 : 16'h0000;
        end
    end

    default clocking ast_clk @(posedge core_clk);
    endclocking
    default disable iff (reset);

    sequence request_dropped;
        pin_fall.request_n && phase != fpl_pkg::phase_por;
    endsequence
    sequence both_lines_low;
        status_n_oe && load_complete_oe;
    endsequence
    sequence word_taken;
        words_rx == $past(words_rx) + 32'h0000_0001;
    endsequence

    AST_REQ_DROPS_LINES: assert property (request_dropped |=> both_lines_low)            // [R4]
        else $error("request low did not drop status and load complete");
    AST_POR_STATUS_LOW: assert property (phase == fpl_pkg::phase_por |-> status_n_oe && load_complete_oe) // [R2]
        else $error("status released during power-on delay");
    AST_LC_LOW_LOADING: assert property (phase == fpl_pkg::phase_load |-> load_complete_oe) // [R3]
        else $error("load complete released during transfer");
    AST_STATUS_MIN_PULSE: assert property ($fell(status_n_oe) && $past(phase) == fpl_pkg::phase_reset_hold
                                           |-> status_low_cnt >= STATUS_LOW_CYCLES)      // [R6]
        else $error("status low pulse too short");
    AST_STATUS_RELEASE: assert property (phase == fpl_pkg::phase_reset_hold && timer_done && pins.request_n
                                         && !pin_fall.request_n |=> !status_n_oe)        // [R7]
        else $error("status not released after request high");
    AST_WORD_PER_EDGE: assert property (word_edge && single_ratio && !image_done && !enter_hold
                                        |=> word_taken)                                  // [R9]
        else $error("word not captured on clock edge");
    AST_NARROW_CLEAN: assert property (word_edge && ctrl.width == fpl_pkg::width_8 && !image_done
                                       && !enter_hold |=> last_word[31:8] == 24'h000000) // [R10]
        else $error("upper lanes not cleared in eight-bit mode");
    AST_LC_AFTER_IMAGE: assert property ($fell(load_complete_oe) |-> $past(words_rx) == $past(word_count)) // [R12]
        else $error("load complete released before whole image");
    AST_OSC_INIT_TIME: assert property ($rose(user_mode) && !ctrl.use_user_clk
                                        |-> init_cnt >= 16'(fpl_pkg::INIT_OSC_MIN_CYCLES)) // [R14]
        else $error("user mode entered too early");
    AST_CLOCK_IGNORED: assert property (user_mode && !pin_fall.request_n |=> $stable(words_rx) && user_mode) // [R16]
        else $error("word clock not ignored in user mode");
    AST_INIT_DONE_LOW: assert property ($rose(init_option) |-> init_done_n_oe && $past(words_rx) == 32'h0000_0000) // [R17]
        else $error("init done not driven low after option word");

endmodule

//--- shared/fpl_pkg.sv
// shared constants, register map and carrier types of the fast parallel load port
package fpl_pkg;

    // ==========================================================
    // clock and widths
    localparam int CLK_PERIOD_NS = 50;
    localparam int DATA_W        = 32;
    localparam int ADDR_W        = 8;
    localparam int TIMER_W       = 16;

    // ==========================================================
    // register byte offsets
    localparam logic [ADDR_W-1:0] CTRL_OFFSET       = 8'h00;
    localparam logic [ADDR_W-1:0] WORD_COUNT_OFFSET = 8'h04;
    localparam logic [ADDR_W-1:0] PHASE_OFFSET      = 8'h08;
    localparam logic [ADDR_W-1:0] WORDS_RX_OFFSET   = 8'h0c;
    localparam logic [ADDR_W-1:0] IRQ_STATUS_OFFSET = 8'h10;
    localparam logic [ADDR_W-1:0] IRQ_MASK_OFFSET   = 8'h14;
    localparam logic [ADDR_W-1:0] LAST_WORD_OFFSET  = 8'h18;

    // ==========================================================
    // modes, states and field layouts
    typedef enum logic [1:0] {width_8, width_16, width_32} bus_width_type;

    typedef enum logic [2:0] {
        phase_por, phase_reset_hold, phase_wait_release, phase_load,
        phase_init, phase_user, phase_error
    } phase_type;

    typedef struct packed {
        logic [26:0]   reserved;
        logic          use_user_clk;
        logic          secure;
        logic          decompress;
        bus_width_type width;
    } ctrl_type;

    typedef struct packed {
        logic load_error;
        logic user_mode;
        logic load_done;
        logic request_seen;
    } irq_type;

    // pin levels sampled together through one synchroniser
    typedef struct packed {
        logic init_done_n;
        logic load_complete;
        logic user_init_clock;
        logic status_n;
        logic request_n;
        logic cfg_word_clock;
    } pin_type;

    // ==========================================================
    // reset values
    localparam ctrl_type          CTRL_RESET       = '0;
    localparam logic [DATA_W-1:0] WORD_COUNT_RESET = 32'h0000_0000;
    localparam irq_type           IRQ_MASK_RESET   = '0;
    localparam int                OPTION_BIT       = 0;

    // ==========================================================
    // timing
    localparam int STATUS_LOW_MIN_US     = 268;
    localparam int STATUS_LOW_MIN_CYCLES = (STATUS_LOW_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int INIT_OSC_MIN_US       = 175;
    localparam int INIT_OSC_MIN_CYCLES   = (INIT_OSC_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int INIT_OSC_MAX_US       = 437;
    localparam int INIT_OSC_MAX_CYCLES   = (INIT_OSC_MAX_US * 1000) / CLK_PERIOD_NS;
    localparam int USRCLK_ENABLE_NS      = 40;
    localparam int USRCLK_ENABLE_RAW     = (USRCLK_ENABLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int USRCLK_ENABLE_CYCLES  = (USRCLK_ENABLE_RAW < 1) ? 1 : USRCLK_ENABLE_RAW;
    localparam int USRCLK_INIT_EDGES     = 8576;
    localparam int POR_DEFAULT_CYCLES    = 1024;
    localparam int PACKED_RATIO          = 4;
    localparam int INIT_FALL_EDGES       = 2;

endpackage

//--- src/edge_sync.sv
// two-flop synchroniser with rising and falling edge detect per bit
`timescale 1ns/1ns
module edge_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             core_clk,
    input  wire logic             reset,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out,
    output logic      [WIDTH-1:0] rise,
    output logic      [WIDTH-1:0] fall
);

    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
    logic [WIDTH-1:0] prev;

    // meta is read only by stable; edges are taken from the second stage onward
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            meta   <= '0;
            stable <= '0;
            prev   <= '0;
        end else begin
            meta   <= async_in;
            stable <= meta;
            prev   <= stable;
        end
    end

    assign sync_out = stable;
    assign rise     = stable & ~prev;
    assign fall     = ~stable & prev;

endmodule

//--- src/interval_timer.sv
// loadable down counter that signals when its interval has run out
`timescale 1ns/1ns
module interval_timer #(
    parameter int                        WIDTH      = 16,
    parameter logic [WIDTH-1:0]          INIT_COUNT = '0
) (
    input  wire logic             core_clk,
    input  wire logic             reset,
    input  wire logic             start,
    input  wire logic [WIDTH-1:0] load_value,
    input  wire logic             tick,
    output logic                  done
);

    logic [WIDTH-1:0] count;

    // start beats tick so a restart never loses a cycle
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            count <= INIT_COUNT;
        end else if (start) begin
            count <= load_value;
        end else if (tick && count != '0) begin
            count <= count - 1'b1;
        end
    end

    assign done = (count == '0);

endmodule

//--- verif/cfg_host_model.sv
// host side model: reconfiguration request pulse and paced word clock
`timescale 1ns/1ns
module cfg_host_model (
    output logic        config_request_n,
    output logic        cfg_word_clock,
    output logic [31:0] cfg_data
);
    // word clock parked low and driven, never left floating
    initial begin
        config_request_n = 1'b1;
        cfg_word_clock   = 1'b0;
        cfg_data         = 32'h0;
    end
    // request held 2.5 us, beyond the minimum low width
    task automatic pulse_request();
        config_request_n = 1'b0;
        #2500 config_request_n = 1'b1;
    endtask
    // 400 ns period, even duty, slow enough for the sampling core clock
    task automatic send_word(input logic [31:0] w);
        cfg_data = w;
        #200 cfg_word_clock = 1'b1;
        #200 cfg_word_clock = 1'b0;
        cfg_data = ~w; // hold over: old word must not linger
    endtask
endmodule

//--- verif/tb_top.sv
// register-level bench of the fast parallel load port
`timescale 1ns/1ns
module tb_top;
    logic        core_clk, reset, reg_write, reg_read, irq, st_oe, lc_oe, id_oe, user_mode;
    logic        st_o, lc_o, id_o, uclk, st_hold;
    logic        config_request_n, cfg_word_clock;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata, cfg_data, v;
    int          err_count, checks_done, n;
    fast_parallel_config_port #(.POR_CYCLES(16'h0010), .STATUS_LOW_CYCLES(16'h0014), .USRCLK_EDGES(16'h0008))
    u_fast_parallel_config_port (.core_clk, .reset, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
        .irq, .config_request_n, .status_n_in(!st_hold & (!st_oe | st_o)), .status_n_out(st_o), .status_n_oe(st_oe),
        .load_complete_in(!lc_oe | lc_o), .load_complete_out(lc_o), .load_complete_oe(lc_oe),
        .init_done_n_in(!id_oe | id_o), .init_done_n_out(id_o), .init_done_n_oe(id_oe), .cfg_word_clock, .cfg_data,
        .user_init_clock(uclk), .user_mode);
    cfg_host_model u_cfg_host_model (.config_request_n, .cfg_word_clock, .cfg_data);
    // core clock, 50 ns
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    // user init clock, 400 ns, free running; ignored unless selected
    initial begin
        uclk = 1'b0;
        forever #200 uclk = ~uclk;
    end
    // watchdog: the full sequence needs about 4000 cycles
    initial begin
        #2000000 err_count++;
        tally_and_finish();
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        checks_done++;
        if (s !== e) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        {reg_addr, reg_wdata, reg_write} <= {a, d, 1'b1};
        @(posedge core_clk);
        reg_write <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge core_clk);
        {reg_addr, reg_read} <= {a, 1'b1};
        @(posedge core_clk);
        reg_read <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // main sequence: power-on, reconfigure with three 8-bit words, initialise
    initial begin
        {st_hold, reset, reg_write, reg_read, reg_addr, reg_wdata, err_count, checks_done} = '0;
        reset = 1'b1;
        repeat (5) @(posedge core_clk);
        reset <= 1'b0;
        @(posedge core_clk);
        #1 chk("por_status", 1, st_oe);
        chk("por_done", 1, lc_oe);
        wr(fpl_pkg::CTRL_OFFSET, 32'h0);
        wr(fpl_pkg::WORD_COUNT_OFFSET, 32'h3);
        wr(fpl_pkg::IRQ_MASK_OFFSET, 32'hf);
        repeat (40) @(posedge core_clk);
        rd(fpl_pkg::IRQ_STATUS_OFFSET, v);
        fork u_cfg_host_model.pulse_request(); join_none
        repeat (12) @(posedge core_clk); // 600 ns
        #1 chk("req_status", 1, st_oe);
        chk("req_done", 1, lc_oe);
        chk("irq", 1, irq);
        repeat (36) @(posedge core_clk);
        #1 chk("status_min", 1, st_oe);
        for (n = 0; n < 40 && st_oe; n++) #50;
        chk("status_rel", 0, st_oe);
        #2000 u_cfg_host_model.send_word(32'h1234_5601);
        repeat (4) @(posedge core_clk);
        #1 chk("init_low", 1, id_oe);
        u_cfg_host_model.send_word(32'hffff_ff3c);
        repeat (4) @(posedge core_clk);
        #1 chk("done_mid", 1, lc_oe);
        u_cfg_host_model.send_word(32'h0000_a5c3);
        repeat (6) @(posedge core_clk);
        #1 chk("done_rise", 0, lc_oe);
        rd(fpl_pkg::LAST_WORD_OFFSET, v);
        chk("last_word", 32'hc3, v);
        repeat (2) u_cfg_host_model.send_word(32'h77);
        rd(fpl_pkg::WORDS_RX_OFFSET, v);
        chk("words_rx", 3, v);
        for (n = 0; n < 9000 && !user_mode; n++) #50;
        chk("init_time", 1, n >= 3440 && n <= 8700);
        #1 chk("user_mode", 1, user_mode);
        chk("user_lines", 0, {st_oe, lc_oe, id_oe});
        rd(fpl_pkg::IRQ_STATUS_OFFSET, v);
        chk("irq_status", 32'h7, v);
        rd(fpl_pkg::IRQ_STATUS_OFFSET, v);
        chk("irq_cleared", 0, v | irq);
        rd(8'h1c, v);
        chk("unmapped", 0, v);
        // second load: 16-bit, every fourth edge, user clock init; a status fault aborts it first
        wr(fpl_pkg::CTRL_OFFSET, 32'h15);
        wr(fpl_pkg::WORD_COUNT_OFFSET, 32'h1);
        #1 u_cfg_host_model.pulse_request();
        for (n = 0; n < 40 && st_oe; n++) #50;
        #500 st_hold = 1'b1;
        #500 st_hold = 1'b0;
        chk("abort_status", 1, st_oe);
        rd(fpl_pkg::IRQ_STATUS_OFFSET, v);
        chk("abort_irq", 32'h9, v);
        #1 u_cfg_host_model.pulse_request();
        for (n = 0; n < 40 && st_oe; n++) #50;
        #2000 repeat (3) u_cfg_host_model.send_word(32'h0);
        u_cfg_host_model.send_word(32'h1234_5678);
        repeat (2) u_cfg_host_model.send_word(32'h0);
        for (n = 0; n < 200 && !user_mode; n++) #50;
        chk("usr_init", 1, user_mode && n >= 30);
        rd(fpl_pkg::LAST_WORD_OFFSET, v);
        chk("last16", 32'h5678, v);
        tally_and_finish();
    end
endmodule
